// ---- logic/poc_pkg.sv ----
// package: register map, reset values and timing constants
package poc_pkg;

    // ========================================================
    // clock and time base
    // ========================================================
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned NS_PER_SEC    = 1_000_000_000;
    localparam int unsigned SEC_CYCLES    = NS_PER_SEC / CLK_PERIOD_NS;

    // ========================================================
    // start-up sequence, in seconds
    // ========================================================
    localparam int unsigned STARTUP_S     = 2;
    localparam int unsigned PURGE_MIN     = 4;
    localparam int unsigned PURGE_S       = PURGE_MIN * 60;
    // warm-up of eight and a half minutes, counted in half minutes
    localparam int unsigned WARM_HALF_MIN = 17;
    localparam int unsigned WARM_S        = WARM_HALF_MIN * 30;
    localparam int unsigned SEQ_W         = 10;

    // ========================================================
    // data widths
    // ========================================================
    localparam int unsigned DATA_W = 16;

    // ========================================================
    // register byte offsets
    // ========================================================
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_ACT_LVL   = 8'h04;
    localparam logic [7:0] OFS_ACT_DLY   = 8'h08;
    localparam logic [7:0] OFS_DEACT_LVL = 8'h0C;
    localparam logic [7:0] OFS_DEACT_DLY = 8'h10;
    localparam logic [7:0] OFS_ERR_LVL   = 8'h14;
    localparam logic [7:0] OFS_STATUS    = 8'h18;
    localparam logic [7:0] OFS_CONC      = 8'h1C;

    // ========================================================
    // field positions
    // ========================================================
    localparam int unsigned CTRL_SUP_EN_BIT   = 0;
    localparam int unsigned STAT_ANALOG_BIT   = 0;
    localparam int unsigned STAT_ACTIVE_BIT   = 1;
    localparam int unsigned STAT_PURGE_BIT    = 2;
    localparam int unsigned STAT_AVAIL_BIT    = 3;
    localparam int unsigned STAT_WARM_BIT     = 4;
    localparam int unsigned STAT_SUPP_BIT     = 5;
    localparam int unsigned STAT_PENDING_BIT  = 6;

    // ========================================================
    // reset values (ppm, seconds, microamps)
    // ========================================================
    localparam logic             RST_SUP_EN    = 1'b0;
    localparam logic [DATA_W-1:0] RST_ACT_LVL   = 16'h0003;
    localparam logic [DATA_W-1:0] RST_ACT_DLY   = 16'h0708;
    localparam logic [DATA_W-1:0] RST_DEACT_LVL = 16'h000A;
    localparam logic [DATA_W-1:0] RST_DEACT_DLY = 16'h000A;
    localparam logic [DATA_W-1:0] RST_ERR_LVL   = 16'h0E10;

    // ========================================================
    // start-up phases
    // ========================================================
    typedef enum logic [2:0] {
        PH_START = 3'b001,
        PH_PURGE = 3'b010,
        PH_RUN   = 3'b100
    } poc_phase_t;

endpackage

// ---- logic/poc_sec_tick.sv ----
// one-second enable pulse divided down from the core clock
module poc_sec_tick #(
    parameter int unsigned CYCLES = 25_000_000
) (
    input  wire logic i_core_clk,
    input  wire logic i_arst_n,
    output logic      o_tick
);

    localparam int unsigned CNT_W = $clog2(CYCLES);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

    logic [CNT_W-1:0] cnt;
    wire              wrap = (cnt == LAST);

    if (CYCLES < 2) begin : g_chk
        $error("poc_sec_tick: CYCLES must be at least 2");
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt    <= '0;
            o_tick <= 1'b0;
        end else begin
            cnt    <= wrap ? '0 : cnt + 1'b1;
            o_tick <= wrap;
        end
    end

endmodule

// ---- logic/poc_suppress.sv ----
// low-reading suppression with activation and deactivation delays
module poc_suppress
    import poc_pkg::*;
(
    input  wire logic              i_core_clk,
    input  wire logic              i_arst_n,
    input  wire logic              i_tick,
    input  wire logic              i_enable,
    input  wire logic [DATA_W-1:0] i_conc,
    input  wire logic [DATA_W-1:0] i_act_lvl,
    input  wire logic [DATA_W-1:0] i_act_dly,
    input  wire logic [DATA_W-1:0] i_deact_lvl,
    input  wire logic [DATA_W-1:0] i_deact_dly,
    output logic                   o_suppressed,
    output logic                   o_pending
);

    logic [DATA_W-1:0] act_cnt;
    logic [DATA_W-1:0] deact_cnt;

    wire below      = (i_conc < i_act_lvl);
    wire above      = (i_conc > i_deact_lvl);
    wire act_done   = below && (act_cnt >= i_act_dly);
    wire deact_done = above && (deact_cnt >= i_deact_dly);

    // =========================================================
    // activation timer
    // =========================================================
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            act_cnt <= '0;
        end else if (!i_enable || !below || deact_done) begin
            act_cnt <= '0;
        end else if (i_tick && !act_done && !o_suppressed) begin
            act_cnt <= act_cnt + 1'b1;
        end
    end

    // =========================================================
    // deactivation timer, also running during activation delay
    // =========================================================
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            deact_cnt <= '0;
        end else if (!i_enable || !above) begin
            deact_cnt <= '0;
        end else if (i_tick && !deact_done) begin
            deact_cnt <= deact_cnt + 1'b1;
        end
    end

    // =========================================================
    // suppression state
    // =========================================================
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_suppressed <= 1'b0;
            o_pending    <= 1'b0;
        end else begin
            o_pending <= i_enable && below && !o_suppressed && !act_done;
            if (!i_enable || deact_done) begin
                o_suppressed <= 1'b0;
            end else if (act_done) begin
                o_suppressed <= 1'b1;
            end
        end
    end

endmodule

// ---- logic/poc_top.sv ----
// probe output conditioning: mode latch, start-up, suppression, registers
//
// Overview of operation
// - sample control pin once; keep that mode
// - never drive analog and digital together
// - activate outputs within start-up time
// - purge after start-up; measurements unavailable
// - analog purge holds both outputs at error
// - below activation level starts activation timer
// - timer expiry forces concentration to zero
// - above deactivation level starts deactivation timer
// - full deactivation delay ends suppression
// - deactivation also cancels pending activation
// - suppression enable defaults off
// - activation level 3, delay 1800, configurable
// - deactivation level 10, delay 10, configurable
// - enabled settings kept in nonvolatile store
// - digital mode uses serial bus framing
module poc_top
    import poc_pkg::*;
#(
    parameter int unsigned SEC_CYCLES_P = poc_pkg::SEC_CYCLES
) (
    input  wire logic                       i_core_clk,
    input  wire logic                       i_arst_n,
    // wishbone classic slave
    input  wire logic                       i_wb_cyc,
    input  wire logic                       i_wb_stb,
    input  wire logic                       i_wb_we,
    input  wire logic [7:0]                 i_wb_adr,
    input  wire logic [3:0]                 i_wb_sel,
    input  wire logic [31:0]                i_wb_dat,
    output logic      [31:0]                o_wb_dat,
    output logic                            o_wb_ack,
    // output control pin: high when floating, low when grounded
    input  wire logic                       i_out_ctrl,
    // measurement path
    input  wire logic [poc_pkg::DATA_W-1:0] i_conc,
    input  wire logic [poc_pkg::DATA_W-1:0] i_aout1_code,
    input  wire logic [poc_pkg::DATA_W-1:0] i_aout2_code,
    // nonvolatile settings store
    input  wire logic                       i_nv_valid,
    input  wire logic                       i_nv_sup_en,
    input  wire logic [poc_pkg::DATA_W-1:0] i_nv_act_lvl,
    input  wire logic [poc_pkg::DATA_W-1:0] i_nv_act_dly,
    input  wire logic [poc_pkg::DATA_W-1:0] i_nv_deact_lvl,
    input  wire logic [poc_pkg::DATA_W-1:0] i_nv_deact_dly,
    output logic                            o_nv_sup_en,
    output logic      [poc_pkg::DATA_W-1:0] o_nv_act_lvl,
    output logic      [poc_pkg::DATA_W-1:0] o_nv_act_dly,
    output logic      [poc_pkg::DATA_W-1:0] o_nv_deact_lvl,
    output logic      [poc_pkg::DATA_W-1:0] o_nv_deact_dly,
    output logic                            o_nv_save,
    // outputs
    output logic                            o_analog_mode,
    output logic                            o_aout_en,
    output logic                            o_serial_en,
    output logic      [poc_pkg::DATA_W-1:0] o_aout1,
    output logic      [poc_pkg::DATA_W-1:0] o_aout2,
    output logic      [poc_pkg::DATA_W-1:0] o_conc,
    output logic                            o_meas_avail,
    output logic                            o_warm
);

    import poc_pkg::*;

    if (SEC_CYCLES_P < 2) begin : g_chk
        $error("poc_top: SEC_CYCLES_P must be at least 2");
    end

    // =========================================================
    // time base
    // =========================================================
    logic sec_tick;

    poc_sec_tick #(
        .CYCLES (SEC_CYCLES_P)
    ) u_tick (
        .i_core_clk (i_core_clk),
        .i_arst_n   (i_arst_n),
        .o_tick     (sec_tick)
    );

    // =========================================================
    // output mode latch, taken once after reset release
    // =========================================================
    logic mode_taken;
    logic analog;

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mode_taken <= 1'b0;
            analog     <= 1'b0;
        end else if (!mode_taken) begin
            mode_taken <= 1'b1;
            analog     <= !i_out_ctrl;
        end
    end

    // =========================================================
    // start-up sequence
    // =========================================================
    localparam logic [SEQ_W-1:0] T_ACTIVE = SEQ_W'(STARTUP_S);
    localparam logic [SEQ_W-1:0] T_PURGED = SEQ_W'(STARTUP_S + PURGE_S);
    localparam logic [SEQ_W-1:0] T_WARM   = SEQ_W'(WARM_S);

    logic [SEQ_W-1:0] sec_cnt;
    poc_phase_t       phase;
    poc_phase_t       next_phase;

    wire seq_running = (sec_cnt != T_WARM);

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sec_cnt <= '0;
        end else if (sec_tick && seq_running) begin
            sec_cnt <= sec_cnt + 1'b1;
        end
    end

    always_comb begin
        next_phase = phase;
        unique case (phase)
            PH_START: begin
                if (sec_cnt >= T_ACTIVE && mode_taken) begin
                    next_phase = PH_PURGE;
                end
            end
            PH_PURGE: begin
                if (sec_cnt >= T_PURGED) begin
                    next_phase = PH_RUN;
                end
            end
            PH_RUN: begin
                next_phase = PH_RUN;
            end
            default: begin
                next_phase = PH_START;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            phase <= PH_START;
        end else begin
            phase <= next_phase;
        end
    end

    wire active   = (phase != PH_START);
    wire in_purge = (phase == PH_PURGE);

    // =========================================================
    // settings registers
    // =========================================================
    logic              sup_en;
    logic [DATA_W-1:0] act_lvl;
    logic [DATA_W-1:0] act_dly;
    logic [DATA_W-1:0] deact_lvl;
    logic [DATA_W-1:0] deact_dly;
    logic [DATA_W-1:0] err_lvl;
    logic              nv_loaded;

    // wishbone decode
    wire        wb_req   = i_wb_cyc && i_wb_stb;
    wire        wb_wr    = wb_req && i_wb_we && o_wb_ack;
    wire [15:0] wdat     = i_wb_dat[15:0];
    wire        lo_lanes = i_wb_sel[0] && i_wb_sel[1];
    wire        wr_ctrl  = wb_wr && (i_wb_adr == OFS_CTRL) && i_wb_sel[0];
    wire        wr_alvl  = wb_wr && (i_wb_adr == OFS_ACT_LVL) && lo_lanes;
    wire        wr_adly  = wb_wr && (i_wb_adr == OFS_ACT_DLY) && lo_lanes;
    wire        wr_dlvl  = wb_wr && (i_wb_adr == OFS_DEACT_LVL) && lo_lanes;
    wire        wr_ddly  = wb_wr && (i_wb_adr == OFS_DEACT_DLY) && lo_lanes;
    wire        wr_err   = wb_wr && (i_wb_adr == OFS_ERR_LVL) && lo_lanes;
    wire        wr_nv    = wr_ctrl || wr_alvl || wr_adly || wr_dlvl || wr_ddly;
    // stored settings are taken once, the cycle after reset release
    wire        nv_load  = !nv_loaded && i_nv_valid;

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            nv_loaded <= 1'b0;
            sup_en    <= RST_SUP_EN;
            act_lvl   <= RST_ACT_LVL;
            act_dly   <= RST_ACT_DLY;
            deact_lvl <= RST_DEACT_LVL;
            deact_dly <= RST_DEACT_DLY;
        end else begin
            nv_loaded <= 1'b1;
            if (nv_load) begin
                sup_en    <= i_nv_sup_en;
                act_lvl   <= i_nv_act_lvl;
                act_dly   <= i_nv_act_dly;
                deact_lvl <= i_nv_deact_lvl;
                deact_dly <= i_nv_deact_dly;
            end else begin
                if (wr_ctrl) sup_en <= i_wb_dat[CTRL_SUP_EN_BIT];
                if (wr_alvl) act_lvl <= wdat;
                if (wr_adly) act_dly <= wdat;
                if (wr_dlvl) deact_lvl <= wdat;
                if (wr_ddly) deact_dly <= wdat;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            err_lvl <= RST_ERR_LVL;
        end else if (wr_err) begin
            err_lvl <= wdat;
        end
    end

    // mirror to the store; a save pulse follows every settings write except the error level
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_nv_save <= 1'b0;
        end else begin
            o_nv_save <= wr_nv && !nv_load;
        end
    end

    assign o_nv_sup_en    = sup_en;
    assign o_nv_act_lvl   = act_lvl;
    assign o_nv_act_dly   = act_dly;
    assign o_nv_deact_lvl = deact_lvl;
    assign o_nv_deact_dly = deact_dly;

    // =========================================================
    // low-reading suppression
    // =========================================================
    logic suppressed;
    logic pending;

    poc_suppress u_sup (
        .i_core_clk   (i_core_clk),
        .i_arst_n     (i_arst_n),
        .i_tick       (sec_tick),
        .i_enable     (sup_en),
        .i_conc       (i_conc),
        .i_act_lvl    (act_lvl),
        .i_act_dly    (act_dly),
        .i_deact_lvl  (deact_lvl),
        .i_deact_dly  (deact_dly),
        .o_suppressed (suppressed),
        .o_pending    (pending)
    );

    // =========================================================
    // output stage, all registered
    // =========================================================
    // the pins are shared, so each driver enable is gated by the
    // latched mode and the end of PH_START; the pin never flips while powered
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_analog_mode <= 1'b0;
            o_aout_en     <= 1'b0;
            o_serial_en   <= 1'b0;
            o_meas_avail  <= 1'b0;
            o_warm        <= 1'b0;
        end else begin
            o_analog_mode <= analog;
            o_aout_en     <= active && analog;
            o_serial_en   <= active && !analog;
            o_meas_avail  <= (phase == PH_RUN);
            o_warm        <= !seq_running;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_conc  <= '0;
            o_aout1 <= '0;
            o_aout2 <= '0;
        end else begin
            o_conc  <= suppressed ? '0 : i_conc;
            o_aout1 <= in_purge ? err_lvl : i_aout1_code;
            o_aout2 <= in_purge ? err_lvl : i_aout2_code;
        end
    end

    // =========================================================
    // wishbone read and acknowledge
    // =========================================================
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        unique case (i_wb_adr)
            OFS_CTRL:      rd_mux[CTRL_SUP_EN_BIT] = sup_en;
            OFS_ACT_LVL:   rd_mux[15:0] = act_lvl;
            OFS_ACT_DLY:   rd_mux[15:0] = act_dly;
            OFS_DEACT_LVL: rd_mux[15:0] = deact_lvl;
            OFS_DEACT_DLY: rd_mux[15:0] = deact_dly;
            OFS_ERR_LVL:   rd_mux[15:0] = err_lvl;
            OFS_STATUS: begin
                rd_mux[STAT_ANALOG_BIT]  = analog;
                rd_mux[STAT_ACTIVE_BIT]  = active;
                rd_mux[STAT_PURGE_BIT]   = in_purge;
                rd_mux[STAT_AVAIL_BIT]   = (phase == PH_RUN);
                rd_mux[STAT_WARM_BIT]    = !seq_running;
                rd_mux[STAT_SUPP_BIT]    = suppressed;
                rd_mux[STAT_PENDING_BIT] = pending;
            end
            OFS_CONC:      rd_mux[15:0] = o_conc;
            default:       rd_mux = '0;
        endcase
    end

    // one wait state; unmapped addresses answer with zero data
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= '0;
        end else begin
            o_wb_ack <= wb_req && !o_wb_ack;
            if (wb_req && !o_wb_ack) begin
                o_wb_dat <= rd_mux;
            end
        end
    end

endmodule

// ---- dv/poc_props.sv ----
// checker: port-level properties of the output conditioning block
module poc_props
    import poc_pkg::*;
(
    input wire logic                       i_core_clk,
    input wire logic                       i_arst_n,
    input wire logic                       i_wb_cyc,
    input wire logic                       i_wb_stb,
    input wire logic                       i_wb_we,
    input wire logic [7:0]                 i_wb_adr,
    input wire logic [3:0]                 i_wb_sel,
    input wire logic                       o_wb_ack,
    input wire logic [poc_pkg::DATA_W-1:0] i_conc,
    input wire logic [poc_pkg::DATA_W-1:0] o_conc,
    input wire logic                       o_nv_save,
    input wire logic                       o_analog_mode,
    input wire logic                       o_aout_en,
    input wire logic                       o_serial_en,
    input wire logic [poc_pkg::DATA_W-1:0] o_aout1,
    input wire logic [poc_pkg::DATA_W-1:0] o_aout2,
    input wire logic                       o_meas_avail,
    input wire logic                       o_warm
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    wire out_on = o_aout_en | o_serial_en;
    wire wr_dly = i_wb_cyc & i_wb_stb & o_wb_ack & i_wb_we
                & (i_wb_sel == 4'hF) & (i_wb_adr == OFS_ACT_DLY);
    // ========================================================
    // properties
    // ========================================================
    property p_excl; !(o_aout_en && o_serial_en); endproperty
    a_excl: assert property (p_excl) else $error("both outputs on");
    property p_mode; out_on |-> (o_aout_en == o_analog_mode); endproperty
    a_mode: assert property (p_mode) else $error("enable vs mode");
    property p_keep; out_on |=> $stable(o_analog_mode); endproperty
    a_keep: assert property (p_keep) else $error("mode changed");
    property p_purge;
        (out_on && !o_meas_avail) [*2] |-> $stable(o_aout1)
            && (o_aout1 == o_aout2);
    endproperty
    a_purge: assert property (p_purge) else $error("purge level");
    property p_avail; $rose(o_meas_avail) |-> out_on; endproperty
    a_avail: assert property (p_avail) else $error("run before on");
    property p_hold; o_meas_avail |=> o_meas_avail; endproperty
    a_hold: assert property (p_hold) else $error("run phase lost");
    property p_warm; o_warm |-> o_meas_avail; endproperty
    a_warm: assert property (p_warm) else $error("warm in purge");
    property p_conc; (o_conc != 16'h0000) |-> o_conc == $past(i_conc);
    endproperty
    a_conc: assert property (p_conc) else $error("conc altered");
    property p_save; wr_dly |=> o_nv_save; endproperty
    a_save: assert property (p_save) else $error("no store save");
    c_run: cover property ($rose(o_meas_avail));
    c_zero: cover property ($fell(|o_conc));
    c_serial: cover property (o_serial_en);
endmodule

// ---- dv/poc_nv_model.sv ----
// model of the nonvolatile settings store beside the block
module poc_nv_model
    import poc_pkg::*;
(
    input  wire logic                       i_core_clk,
    input  wire logic                       i_save,
    input  wire logic                       i_sup_en,
    input  wire logic [poc_pkg::DATA_W-1:0] i_act_lvl,
    input  wire logic [poc_pkg::DATA_W-1:0] i_act_dly,
    input  wire logic [poc_pkg::DATA_W-1:0] i_deact_lvl,
    input  wire logic [poc_pkg::DATA_W-1:0] i_deact_dly,
    output logic                            o_valid,
    output logic                            o_sup_en,
    output logic      [poc_pkg::DATA_W-1:0] o_act_lvl,
    output logic      [poc_pkg::DATA_W-1:0] o_act_dly,
    output logic      [poc_pkg::DATA_W-1:0] o_deact_lvl,
    output logic      [poc_pkg::DATA_W-1:0] o_deact_dly
);
    timeunit 1ns;
    timeprecision 1ns;
    // no reset: contents outlive a block reset; unknown until first save
    initial o_valid = 1'b0;
    always @(posedge i_core_clk) begin
        if (i_save === 1'b1) begin
            o_valid <= 1'b1;
            {o_sup_en, o_act_lvl} <= {i_sup_en, i_act_lvl};
            {o_act_dly, o_deact_lvl} <= {i_act_dly, i_deact_lvl};
            o_deact_dly <= i_deact_dly;
        end
    end
endmodule

// ---- dv/testbench.sv ----
// testbench: start-up, mode latch, registers and suppression
module testbench;
    import poc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SC = 10;
    logic        clk = 1'b0, rst_n = 1'b0, ctl = 1'b0;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'hF;
    logic [31:0] wdat = 32'h0, q;
    logic [15:0] conc = 16'h0005, a1 = 16'h1234, a2 = 16'h2345;
    wire         ack, nv_save, amode, aen, sen, avail, warm, nv_ok, nv_en;
    wire         s_en;
    wire  [31:0] rd;
    wire  [15:0] aout1, aout2, oconc, nv_al, nv_ad, nv_dl, nv_dd;
    wire  [15:0] s_al, s_ad, s_dl, s_dd;
    int          num_errors = 0, tests_run = 0, cyc_cnt = 0, n, t0;

    always #20 clk = ~clk;

    poc_top #(.SEC_CYCLES_P(SC)) i_dut (
        .i_core_clk(clk), .i_arst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_dat(rd), .o_wb_ack(ack), .i_out_ctrl(ctl), .i_conc(conc),
        .i_aout1_code(a1), .i_aout2_code(a2), .i_nv_valid(nv_ok),
        .i_nv_sup_en(nv_en), .i_nv_act_lvl(nv_al), .i_nv_act_dly(nv_ad),
        .i_nv_deact_lvl(nv_dl), .i_nv_deact_dly(nv_dd), .o_nv_sup_en(s_en),
        .o_nv_act_lvl(s_al), .o_nv_act_dly(s_ad), .o_nv_deact_lvl(s_dl),
        .o_nv_deact_dly(s_dd), .o_nv_save(nv_save), .o_analog_mode(amode),
        .o_aout_en(aen), .o_serial_en(sen), .o_aout1(aout1),
        .o_aout2(aout2), .o_conc(oconc), .o_meas_avail(avail), .o_warm(warm));

    poc_nv_model i_nv (
        .i_core_clk(clk), .i_save(nv_save), .i_sup_en(s_en),
        .i_act_lvl(s_al), .i_act_dly(s_ad), .i_deact_lvl(s_dl),
        .i_deact_dly(s_dd), .o_valid(nv_ok), .o_sup_en(nv_en),
        .o_act_lvl(nv_al), .o_act_dly(nv_ad), .o_deact_lvl(nv_dl),
        .o_deact_dly(nv_dd));

    // ========================================================
    // tasks
    // ========================================================
    task automatic summarize();
        if (num_errors == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // read data is taken at the acking edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do @(posedge clk); while (ack !== 1'b1);
        q = rd;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, logic [31:0] e);
        wb(1'b0, a, 32'h0);
        check(nm, q, e);
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t0 = cyc_cnt;
    endtask

    always @(posedge clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 9000) begin
            num_errors++;
            summarize();
        end
    end

    // ========================================================
    // sequence
    // ========================================================
    initial begin
        do_reset();
        while (aen !== 1'b1) @(posedge clk);
        n = cyc_cnt - t0;
        check("start", 32'(n >= 2*SC - 1 && n <= 2*SC + 4), 1);
        check("amode", amode, 1);
        check("sen", sen, 0);
        check("aout1", aout1, RST_ERR_LVL);
        check("aout2", aout2, RST_ERR_LVL);
        check("avail", avail, 0);
        // pin moved without a power cycle: the mode must not follow
        ctl <= 1'b1;
        rdchk("ctrl", OFS_CTRL, 0);
        rdchk("alvl", OFS_ACT_LVL, RST_ACT_LVL);
        rdchk("adly", OFS_ACT_DLY, RST_ACT_DLY);
        rdchk("dlvl", OFS_DEACT_LVL, RST_DEACT_LVL);
        rdchk("ddly", OFS_DEACT_DLY, RST_DEACT_DLY);
        rdchk("unmap", 8'h40, 0);
        rdchk("stat", OFS_STATUS, 32'h07);
        while (avail !== 1'b1) @(posedge clk);
        n = cyc_cnt - t0;
        check("purge", 32'(n >= 242*SC && n <= 242*SC + 4), 1);
        repeat (2) @(posedge clk);
        check("run aout1", aout1, a1);
        check("kept", amode, 1);
        rdchk("stat run", OFS_STATUS, 32'h0B);
        conc <= 16'h0002;
        wb(1'b1, OFS_ACT_DLY, 3);
        wb(1'b1, OFS_DEACT_DLY, 2);
        wb(1'b1, OFS_CTRL, 1);
        repeat (2*SC - 3) @(posedge clk);
        check("early", oconc, 2);
        repeat (SC + 6) @(posedge clk);
        check("forced", oconc, 0);
        wb(1'b0, OFS_STATUS, 0);
        check("supp", q[STAT_SUPP_BIT], 1);
        conc <= 16'h0014;
        repeat (SC - 3) @(posedge clk);
        check("held", oconc, 0);
        repeat (SC + 6) @(posedge clk);
        check("released", oconc, 16'h0014);
        // a broken dip restarts the activation count
        conc <= 16'h0001;
        repeat (2*SC - 3) @(posedge clk);
        conc <= 16'h0005;
        repeat (SC) @(posedge clk);
        conc <= 16'h0001;
        repeat (SC + 2) @(posedge clk);
        wb(1'b0, OFS_STATUS, 0);
        check("pending", q[STAT_PENDING_BIT], 1);
        check("restart", oconc, 16'h0001);
        conc <= 16'h0014;
        repeat (2*SC + 6) @(posedge clk);
        wb(1'b0, OFS_STATUS, 0);
        check("cancel", q[STAT_PENDING_BIT], 0);
        check("no supp", q[STAT_SUPP_BIT], 0);
        check("normal", oconc, 16'h0014);
        do_reset();
        rdchk("nv en", OFS_CTRL, 1);
        rdchk("nv adly", OFS_ACT_DLY, 3);
        rdchk("nv ddly", OFS_DEACT_DLY, 2);
        check("digital", amode, 0);
        while (sen !== 1'b1) @(posedge clk);
        check("aen", aen, 0);
        while (warm !== 1'b1) @(posedge clk);
        n = cyc_cnt - t0;
        check("warm", 32'(n >= 510*SC && n <= 510*SC + 4), 1);
        check("sen on", sen, 1);
        summarize();
    end
endmodule

bind poc_top poc_props i_props (
    .i_core_clk, .i_arst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
    .i_wb_sel, .o_wb_ack, .i_conc, .o_conc, .o_nv_save, .o_analog_mode,
    .o_aout_en, .o_serial_en, .o_aout1, .o_aout2, .o_meas_avail, .o_warm);
